// ### ascc_pkg.sv
`default_nettype none

package ascc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTL_ADDR      = 8'h00;
    localparam logic [7:0]  OVS_ADDR      = 8'h04;
    localparam logic [7:0]  ASSIGN_ADDR   = 8'h14;
    localparam logic [31:0] ASSIGN_RESET  = 32'h0000_0010;
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_SYNC_BIT  = 0;
    localparam int CTL_INIT_BIT  = 1;
    localparam int CTL_CAL_BIT   = 2;
    localparam int CTL_PASS_BIT  = 3;
    localparam int CTL_READY_BIT = 4;
    localparam int CTL_EVSEL_LO  = 5;
    localparam logic [1:0] EVSEL_NONE  = 2'h0;
    localparam logic [1:0] EVSEL_CAL   = 2'h1;
    localparam logic [1:0] EVSEL_READY = 2'h2;
    // ----------------------------------------------------------------
    // Assignment codes and group sources
    // ----------------------------------------------------------------
    localparam logic [3:0] CODE_GEN_A = 4'h0;
    localparam logic [3:0] CODE_GEN_B = 4'h1;
    localparam logic [3:0] CODE_EXT   = 4'h4;
    localparam logic [1:0] SRC_OFF    = 2'h0;
    localparam logic [1:0] SRC_GEN_A  = 2'h1;
    localparam logic [1:0] SRC_GEN_B  = 2'h2;
    localparam logic [1:0] SRC_EXT    = 2'h3;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ      = 50_000;
    localparam int SYNC_TIME_US = 4000;
    localparam int SYNC_CYC     = SYNC_TIME_US * CLK_KHZ / 1000;
    localparam int CAL_TIME_MS  = 5000;
    localparam int CAL_CYC      = CAL_TIME_MS * CLK_KHZ;
    localparam int FRAME_FULL   = 32;
    localparam int FRAME_HALF   = 16;
    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SQ_IDLE  = 3'b001,
        SQ_PULSE = 3'b010,
        SQ_WAIT  = 3'b100
    } ascc_seq_t;

    typedef enum logic [1:0] {
        CL_IDLE = 2'b01,
        CL_RUN  = 2'b10
    } ascc_cal_t;
endpackage

`default_nettype wire

// ### ascc_ctrl.sv
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none

module ascc_ctrl
    import ascc_pkg::*;
#(
    parameter int  SYNC_CYCLES = SYNC_CYC,
    parameter int  CAL_CYCLES  = CAL_CYC,
    parameter bit  HAS_EXT_OPT = 1'b0
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // AXI4-Lite write
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // Board clocking and sync pins
    input  wire logic        multiboard_en,
    input  wire logic        ext_clk_in,
    input  wire logic        ext_sync_in,
    input  wire logic        gen_a_tick,
    input  wire logic        gen_b_tick,
    output logic             ext_clk_out,
    // Converter control
    output logic [1:0]       grp0_src,
    output logic [1:0]       grp1_src,
    output logic [1:0]       conv_start,
    output logic             adc_sync,
    // Calibration engine
    output logic             cal_busy,
    input  wire logic        cal_done,
    input  wire logic        cal_all_ok,
    // Selected event
    output logic             event_pulse
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic        sync_bit_reg;
    logic        init_reg;
    logic        cal_bit_reg;
    logic        pass_reg;
    logic        ready_reg;
    logic [1:0]  evsel_reg;
    logic [7:0]  assign_reg;
    logic [1:0]  ovs_half_reg;
    ascc_seq_t   seq_reg;
    ascc_cal_t   cal_reg;
    logic [31:0] seq_cnt_reg;
    logic [31:0] cal_cnt_reg;
    logic        sync_in_d_reg;
    logic        ext_clk_d_reg;
    logic [4:0]  frame_cnt_reg [2];
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    logic        wr_fire;
    logic        rd_fire;
    logic        wr_ctl;
    logic        ext_sync_rise;
    logic        ext_edge;
    logic        seq_done;
    logic        cal_finish;
    logic        any_on;
    logic [1:0]  src_next [2];
    logic [1:0]  tick;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] code_src(input logic [3:0] code,
                                            input logic       ext_ok);
        case (code)
            CODE_GEN_A: code_src = SRC_GEN_A;
            CODE_GEN_B: code_src = SRC_GEN_B;
            CODE_EXT:   code_src = ext_ok ? SRC_EXT : SRC_OFF;
            default:    code_src = SRC_OFF;
        endcase
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       en);
        merge8 = en ? nw : old;
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    assign wr_fire = aw_held_reg && w_held_reg && !s_bvalid;
    assign rd_fire = s_arvalid && s_arready;
    assign wr_ctl  = wr_fire && (aw_addr_reg == CTL_ADDR) && w_strb_reg[0];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            s_awready   <= 1'b1;
            s_wready    <= 1'b1;
            s_bvalid    <= 1'b0;
            s_bresp     <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_awvalid && s_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_awaddr;
                s_awready   <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
                s_wready   <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                s_bvalid    <= 1'b1;
                case (aw_addr_reg)
                    CTL_ADDR, OVS_ADDR, ASSIGN_ADDR: s_bresp <= RESP_OKAY;
                    default:                         s_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_fire)
            begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rresp   <= RESP_OKAY;
                case (s_araddr)
                    CTL_ADDR:
                        s_rdata <= {25'h0, evsel_reg, ready_reg, pass_reg,
                                    cal_bit_reg, init_reg, sync_bit_reg};
                    OVS_ADDR:    s_rdata <= {30'h0, ovs_half_reg};
                    ASSIGN_ADDR: s_rdata <= {24'h0, assign_reg};
                    default:
                    begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            init_reg     <= 1'b0;
            evsel_reg    <= EVSEL_NONE;
            assign_reg   <= ASSIGN_RESET[7:0];
            ovs_half_reg <= 2'h0;
        end
        else if (ce && wr_fire)
        begin
            case (aw_addr_reg)
                CTL_ADDR:
                if (w_strb_reg[0])
                begin
                    init_reg  <= w_data_reg[CTL_INIT_BIT];
                    evsel_reg <= w_data_reg[CTL_EVSEL_LO +: 2];
                end
                OVS_ADDR:
                if (w_strb_reg[0])
                    ovs_half_reg <= w_data_reg[1:0];
                ASSIGN_ADDR:
                    assign_reg <= merge8(assign_reg, w_data_reg[7:0],
                                         w_strb_reg[0]);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Clock sources per group
    // ----------------------------------------------------------------
    always_comb
    begin
        src_next[0] = code_src(assign_reg[3:0],
                               !init_reg || HAS_EXT_OPT);
        src_next[1] = code_src(assign_reg[7:4],
                               !init_reg || (HAS_EXT_OPT &&
                               assign_reg[3:0] == CODE_EXT));
    end

    assign ext_edge = ext_clk_in && !ext_clk_d_reg;

    always_comb
    begin
        for (int g = 0; g < 2; g++)
        begin
            case (src_next[g])
                SRC_GEN_A: tick[g] = gen_a_tick;
                SRC_GEN_B: tick[g] = gen_b_tick;
                SRC_EXT:   tick[g] = ext_edge;
                default:   tick[g] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            grp0_src      <= SRC_OFF;
            grp1_src      <= SRC_OFF;
            ext_clk_out   <= 1'b0;
            ext_clk_d_reg <= 1'b0;
        end
        else if (ce)
        begin
            grp0_src      <= src_next[0];
            grp1_src      <= src_next[1];
            ext_clk_out   <= init_reg ? 1'b0 : ext_clk_in;
            ext_clk_d_reg <= ext_clk_in;
        end
    end

    // ----------------------------------------------------------------
    // Conversion frames
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_cnt_reg[0] <= 5'h00;
            frame_cnt_reg[1] <= 5'h00;
            conv_start       <= 2'h0;
        end
        else if (ce)
        begin
            for (int g = 0; g < 2; g++)
            begin
                conv_start[g] <= 1'b0;
                if (adc_sync)
                    frame_cnt_reg[g] <= 5'h00;
                else if (tick[g])
                begin
                    if (frame_cnt_reg[g] == 5'(ovs_half_reg[g] ?
                        FRAME_HALF - 1 : FRAME_FULL - 1))
                    begin
                        frame_cnt_reg[g] <= 5'h00;
                        conv_start[g]    <= 1'b1;
                    end
                    else
                        frame_cnt_reg[g] <= frame_cnt_reg[g] + 5'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Synchronization sequence
    // ----------------------------------------------------------------
    assign ext_sync_rise = multiboard_en && ext_sync_in && !sync_in_d_reg;
    assign seq_done = (seq_reg == SQ_WAIT) &&
                      (seq_cnt_reg == 32'(SYNC_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_reg       <= SQ_IDLE;
            seq_cnt_reg   <= 32'h0000_0000;
            sync_bit_reg  <= 1'b0;
            sync_in_d_reg <= 1'b0;
            adc_sync      <= 1'b0;
        end
        else if (ce)
        begin
            sync_in_d_reg <= ext_sync_in;
            adc_sync      <= 1'b0;
            if (ext_sync_rise)
            begin
                seq_reg <= SQ_PULSE;
            end
            else
            begin
                case (seq_reg)
                    SQ_IDLE:
                    if (wr_ctl && w_data_reg[CTL_SYNC_BIT])
                    begin
                        sync_bit_reg <= 1'b1;
                        seq_reg      <= SQ_PULSE;
                    end
                    SQ_PULSE:
                    begin
                        adc_sync    <= 1'b1;
                        seq_cnt_reg <= 32'h0000_0000;
                        seq_reg     <= SQ_WAIT;
                    end
                    SQ_WAIT:
                    if (seq_done)
                    begin
                        sync_bit_reg <= 1'b0;
                        seq_reg      <= SQ_IDLE;
                    end
                    else
                        seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
                    default: seq_reg <= SQ_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Autocalibration
    // ----------------------------------------------------------------
    assign cal_finish = (cal_reg == CL_RUN) &&
        (cal_done || cal_cnt_reg == 32'(CAL_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cal_reg     <= CL_IDLE;
            cal_cnt_reg <= 32'h0000_0000;
            cal_bit_reg <= 1'b0;
            pass_reg    <= 1'b0;
            cal_busy    <= 1'b0;
        end
        else if (ce)
        begin
            case (cal_reg)
                CL_IDLE:
                if (wr_ctl && w_data_reg[CTL_CAL_BIT])
                begin
                    cal_bit_reg <= 1'b1;
                    cal_busy    <= 1'b1;
                    cal_cnt_reg <= 32'h0000_0000;
                    cal_reg     <= CL_RUN;
                end
                CL_RUN:
                if (cal_finish)
                begin
                    cal_bit_reg <= 1'b0;
                    cal_busy    <= 1'b0;
                    pass_reg    <= cal_done && cal_all_ok;
                    cal_reg     <= CL_IDLE;
                end
                else
                    cal_cnt_reg <= cal_cnt_reg + 32'h0000_0001;
                default: cal_reg <= CL_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Ready flag and event selection
    // ----------------------------------------------------------------
    assign any_on = (src_next[0] != SRC_OFF) || (src_next[1] != SRC_OFF);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_reg   <= 1'b0;
            event_pulse <= 1'b0;
        end
        else if (ce)
        begin
            ready_reg <= any_on && !sync_bit_reg &&
                         (seq_reg == SQ_IDLE) && !ext_sync_rise;
            case (evsel_reg)
                EVSEL_CAL:   event_pulse <= cal_finish;
                EVSEL_READY: event_pulse <= any_on && !ready_reg &&
                    !sync_bit_reg && (seq_reg == SQ_IDLE) &&
                    !ext_sync_rise;
                default:     event_pulse <= 1'b0;
            endcase
        end
    end

endmodule // ascc_ctrl

`default_nettype wire

// ### ascc_ctrl_chk.sv
`default_nettype none
module ascc_ctrl_chk
    import ascc_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYC
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Bus handshake
    input  wire logic        s_awvalid,
    input  wire logic        s_awready,
    input  wire logic        s_wvalid,
    input  wire logic        s_wready,
    input  wire logic [1:0]  s_bresp,
    input  wire logic        s_bvalid,
    input  wire logic        s_bready,
    input  wire logic        s_arvalid,
    input  wire logic        s_arready,
    input  wire logic [31:0] s_rdata,
    input  wire logic        s_rvalid,
    input  wire logic        s_rready,
    // Board pins
    input  wire logic        ext_clk_in,
    input  wire logic        ext_clk_out,
    input  wire logic        adc_sync,
    input  wire logic        cal_busy,
    input  wire logic        cal_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cal_len;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Autocal length
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cal_len <= 0;
        else
            cal_len <= cal_busy ? cal_len + 1 : 0;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_write_answer: assert property (s_awvalid && s_awready && s_wvalid
        && s_wready && ce |=> ##1 s_bvalid) else $error("write not answered");
    a_write_hold: assert property (s_bvalid && !s_bready |=> s_bvalid
        && $stable(s_bresp)) else $error("write answer dropped");
    a_write_block: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_arvalid && s_arready && ce |=>
        s_rvalid && !s_arready) else $error("read not answered");
    a_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid
        && $stable(s_rdata)) else $error("read answer dropped");
    a_clk_copy: assert property (ce && ext_clk_out |-> $past(ext_clk_in))
        else $error("clock output not a copy of input");
    a_sync_pulse: assert property (adc_sync |=> !adc_sync)
        else $error("sync pulse too long");
    a_cal_start: assert property ($rose(cal_busy) |-> $rose(s_bvalid))
        else $error("autocal started without a write");
    a_cal_done_end: assert property (cal_busy && cal_done && ce |=>
        !cal_busy) else $error("autocal not ended by done");
    a_cal_bound: assert property (cal_len <= CAL_CYCLES + 2)
        else $error("autocal too long");
    c_cal_end: cover property ($fell(cal_busy));
    c_sync: cover property (adc_sync);
    c_read: cover property (s_rvalid && s_rready);
endmodule // ascc_ctrl_chk

bind ascc_ctrl ascc_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) ascc_ctrl_chk_i (
    .clk, .rstn, .ce, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata,
    .s_rvalid, .s_rready, .ext_clk_in, .ext_clk_out, .adc_sync,
    .cal_busy, .cal_done);
`default_nettype wire

// ### ascc_cal_model.sv
`default_nettype none
module ascc_cal_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Bench control
    input  wire logic [15:0] delay,
    input  wire logic        ok,
    // Calibration handshake
    input  wire logic        cal_busy,
    output logic             cal_done,
    output logic             cal_all_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_reg;
    logic        busy_reg;
    // Engine answers a set delay after busy rises
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg  <= 16'h0;
            busy_reg <= 1'b0;
            cal_done <= 1'b0;
        end
        else
        begin
            busy_reg <= cal_busy;
            if (cal_busy && !busy_reg)
                cnt_reg <= 16'h1;
            else if (cnt_reg != 16'h0)
                cnt_reg <= cnt_reg + 16'h1;
            cal_done <= (cnt_reg == delay);
        end
    end
    // Result level wanders when not beside done
    assign cal_all_ok = cal_done ? ok : cnt_reg[0];
endmodule // ascc_cal_model
`default_nettype wire

// ### ascc_ctrl_test.sv
`default_nettype none
module ascc_ctrl_test
    import ascc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hf};
    localparam logic [1:0] SRCS [5] =
        '{SRC_GEN_A, SRC_GEN_B, SRC_EXT, SRC_OFF, SRC_OFF};
    logic        clk, rstn, ce, s_awvalid, s_wvalid, s_bready, s_arvalid;
    logic        s_rready, multiboard_en, ext_clk_in, ext_sync_in, cal_ok;
    logic        gen_a_tick, gen_b_tick, s_awready, s_wready, s_bvalid;
    logic        s_arready, s_rvalid, ext_clk_out, adc_sync, cal_busy;
    logic        cal_done, cal_all_ok, event_pulse;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, grp0_src, grp1_src, conv_start, rs;
    logic [15:0] cal_delay;
    int          miscompares, comparisons, cycles, ev_n, sync_n;
    int          conv_n, tick_n, frame_ticks, n, e0, s0;

    ascc_ctrl #(.SYNC_CYCLES(20), .CAL_CYCLES(50)) ascc_ctrl_i (.*);
    ascc_cal_model ascc_cal_model_i (.clk, .rstn, .delay(cal_delay),
        .ok(cal_ok), .cal_busy, .cal_done, .cal_all_ok);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Monitors, generator ticks and timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        gen_a_tick <= ~gen_a_tick;
        gen_b_tick <= gen_a_tick;
        ev_n += event_pulse;
        sync_n += adc_sync;
        tick_n += gen_a_tick;
        if (conv_start[0])
        begin
            frame_ticks = tick_n;
            tick_n = 0;
            conv_n++;
        end
        if (++cycles == 20000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, s);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] st = 4'hf);
        logic aw_d, w_d;
        @(posedge clk);
        {s_awaddr, s_wdata, s_wstrb} <= {a, d, st};
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        {aw_d, w_d} = 2'h0;
        while (!(aw_d && w_d))
        begin
            @(posedge clk);
            aw_d |= s_awready;
            w_d |= s_wready;
            s_awvalid <= !aw_d;
            s_wvalid <= !w_d;
        end
        do @(posedge clk); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk("bresp", RESP_OKAY, s_bresp);
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, e,
                       input logic [1:0] r = RESP_OKAY);
        @(posedge clk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do @(posedge clk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge clk); while (s_rvalid !== 1'b1);
        {rd, rs} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
        chk("rdata", e, rd & m);
        chk("rresp", r, rs);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        axr(ASSIGN_ADDR, 32'hffff_ffff, ASSIGN_RESET);
        axr(CTL_ADDR, 32'h0000_000f, 32'h0);
        axr(8'h40, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    endtask
    task automatic t_assign;
        for (int i = 0; i < 5; i++)
        begin
            axw(ASSIGN_ADDR, {24'h0, CODES[i], CODES[i]});
            chk("grp0_src", SRCS[i], grp0_src);
            chk("grp1_src", SRCS[i], grp1_src);
        end
        axw(ASSIGN_ADDR, 32'h11, 4'h0);
        chk("strb0", SRC_OFF, grp0_src);
        axw(CTL_ADDR, 32'h2);
        axw(ASSIGN_ADDR, 32'h44);
        chk("init_ext", SRC_OFF, grp0_src);
        axw(CTL_ADDR, 32'h0);
        axw(ASSIGN_ADDR, 32'h0);
        for (int h = 0; h < 2; h++)
        begin
            axw(OVS_ADDR, h);
            n = conv_n;
            for (int k = 0; k < 600 && conv_n < n + 3; k++) @(posedge clk);
            chk("frame", h ? FRAME_HALF : FRAME_FULL, frame_ticks);
        end
        axw(OVS_ADDR, 32'h0);
    endtask
    task automatic t_sync;
        {e0, s0} = {ev_n, sync_n};
        axw(CTL_ADDR, 32'h41);
        axr(CTL_ADDR, 32'h1, 32'h1);
        axw(CTL_ADDR, 32'h41);
        rd = 32'h1;
        for (int k = 0; k < 30 && rd[0] !== 1'b0; k++)
            axr(CTL_ADDR, 32'h0, 32'h0);
        chk("sync_bit", 32'h0, {31'h0, rd[0]});
        axr(CTL_ADDR, 32'h11, 32'h10);
        chk("sync_count", 1, sync_n - s0);
        chk("ready_event", 1, ev_n - e0);
    endtask
    task automatic t_ext_sync;
        multiboard_en <= 1'b1;
        for (int p = 1; p < 3; p++)
        begin
            s0 = sync_n;
            @(posedge clk);
            ext_sync_in <= 1'b1;
            repeat (2) @(posedge clk);
            ext_sync_in <= 1'b0;
            repeat (4) @(posedge clk);
            chk("ext_sync", 1, sync_n - s0);
            axr(CTL_ADDR, 32'h1, 32'h0);
            repeat (30) @(posedge clk);
        end
    endtask
    task automatic t_cal;
        for (int i = 0; i < 3; i++)
        begin
            cal_delay <= (i == 2) ? 16'd200 : 16'd10;
            cal_ok <= (i != 1);
            e0 = ev_n;
            axw(CTL_ADDR, 32'h24);
            for (int k = 0; k < 100 && cal_busy !== 1'b0; k++) @(posedge clk);
            axr(CTL_ADDR, 32'hc, (i == 0) ? 32'h8 : 32'h0);
            chk("cal_event", 1, ev_n - e0);
        end
    endtask
    task automatic t_clk;
        axw(CTL_ADDR, 32'h0);
        for (int v = 1; v < 4; v++)
        begin
            @(posedge clk);
            ext_clk_in <= v[0];
            repeat (2) @(posedge clk);
            #1 chk("clk_out", v[0], ext_clk_out);
        end
        axw(CTL_ADDR, 32'h2);
        axr(CTL_ADDR, 32'h2, 32'h2);
        @(posedge clk);
        ext_clk_in <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("clk_init", 32'h0, ext_clk_out);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
        {multiboard_en, ext_clk_in, ext_sync_in, gen_a_tick} = 4'h0;
        {gen_b_tick, cal_ok, s_awaddr, s_araddr, s_wdata} = 50'h0;
        {ce, s_wstrb, cal_delay} = {1'b1, 4'hf, 16'd10};
        {miscompares, comparisons, cycles, ev_n, sync_n} = '0;
        {conv_n, tick_n, frame_ticks} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_assign;
        t_sync;
        t_ext_sync;
        t_cal;
        t_clk;
        give_verdict;
    end
endmodule // ascc_ctrl_test
`default_nettype wire
